/* hdl/cfq_fifo_tx.sv */
// Common FIFO transmit queue with interval timer and APB registers
//
// Functional notes
// - Sends data and remote frames from FIFO
// - Sixteen entries, strict first-in first-out
// - Mode bit selects receive or transmit
// - Two-bit field picks linked transmit slot
// - Only head message offered for priority
// - Disable aborts frame, flushes, empty reads one
// - No abort interrupt; finishing frame may flag
// - Interval counts after EOF bit seven
// - Elapsed interval starts next, clears count
// - Timer stops on disable or channel reset
// - Source 00 ticks every prescaler clocks
// - Source 10 ticks ten prescaled periods
// - Source x1 counts bit-time clocks
// - Interval multiplier is eight-bit field
// - Request issued promptly to transmitter
// - Irq on empty-after-send or every message
// - Per-FIFO enable gates only FIFO flag in channel transmit irq
// - Disable leaves irq flag; software clears
// - Sources register shows merged transmit irqs
module cfq_fifo_tx #(
	parameter int DEPTH = cfq_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_nominal_bit_tick,
	input wire logic i_data_bit_tick,
	input wire logic i_eof_bit7,
	input wire logic i_tx_done,
	input wire logic i_buf_tx_irq,
	input wire logic i_buf_abort_irq,
	input wire logic i_history_irq,
	output cfq_pkg::cfq_tx_req_s o_tx_req,
	output logic o_tx_abort,
	output logic o_tx_irq
);

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------
	// Registers and storage
	// ----------------------------------------
	logic [3:0] cfg_lower;
	logic [11:0] cfg_upper;
	logic [15:0] interval_prescaler;
	logic [1:0] chan_ctrl;
	logic [28:0] stage_id;
	logic stage_remote;
	logic [31:0] stage_data;
	cfq_pkg::cfq_msg_s mem [DEPTH];
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] wr_ptr;
	logic [AW:0] count;
	logic fifo_tx_irq_flag;
	cfq_pkg::cfq_state_e state;
	logic [15:0] pre_cnt;
	logic [3:0] ten_cnt;
	logic [7:0] interval_count;
	logic first_sent;
	logic await_eof;
	logic [31:0] lower_word;
	logic [31:0] upper_word;
	logic [31:0] status_word;

	wire logic fifo_enable = cfg_lower[cfq_pkg::CFG_ENABLE_BIT];
	wire logic tx_mode = cfg_lower[cfq_pkg::CFG_TX_MODE_BIT];
	wire logic fifo_tx_irq_enable = cfg_lower[cfq_pkg::CFG_IRQ_ENABLE_BIT];
	wire logic fifo_irq_mode = cfg_lower[cfq_pkg::CFG_IRQ_MODE_BIT];
	wire logic [7:0] interval_field = cfg_upper[cfq_pkg::UP_INTERVAL_LSB +: 8];
	wire logic interval_source_select = cfg_upper[cfq_pkg::UP_SOURCE_BIT];
	wire logic interval_tenfold_select = cfg_upper[cfq_pkg::UP_TENFOLD_BIT];
	wire logic [1:0] fifo_link_slot_select =
		cfg_upper[cfq_pkg::UP_LINK_LSB +: 2];
	wire logic chan_reset = chan_ctrl[cfq_pkg::CH_RESET_BIT];
	wire logic active = fifo_enable & tx_mode & ~chan_reset;
	wire logic fifo_empty_flag = (count == '0);
	wire logic fifo_full = (count == (AW+1)'(DEPTH));

	wire logic wr_access = i_psel & i_penable & i_pwrite;
	wire logic push = wr_access & (i_paddr == cfq_pkg::ADDR_MSG_PUSH)
		& ~fifo_full;
	wire logic done_ok = (state == cfq_pkg::CFQ_WAIT_DONE) & i_tx_done;
	wire logic pop = done_ok & ~fifo_empty_flag;
	wire logic last_left = (count == (AW+1)'(1)) & ~push;
	wire logic clr_irq = wr_access & (i_paddr == cfq_pkg::ADDR_STATUS)
		& i_pwdata[cfq_pkg::ST_IRQ_FLAG_BIT];
	wire logic [3:0] global_tx_irq_sources = {i_history_irq,
		fifo_tx_irq_flag & fifo_tx_irq_enable, i_buf_abort_irq,
		i_buf_tx_irq};

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg_lower <= cfq_pkg::RST_CONFIG_LOWER[3:0];
			cfg_upper <= cfq_pkg::RST_CONFIG_UPPER[11:0];
			interval_prescaler <= cfq_pkg::RST_PRESCALER;
			chan_ctrl <= cfq_pkg::RST_CHAN_CTRL;
			stage_id <= '0;
			stage_remote <= 1'b0;
			stage_data <= '0;
		end else if (wr_access) begin
			unique case (i_paddr)
				cfq_pkg::ADDR_CONFIG_LOWER: cfg_lower <= i_pwdata[3:0];
				cfq_pkg::ADDR_CONFIG_UPPER: cfg_upper <= i_pwdata[11:0];
				cfq_pkg::ADDR_GLOBAL_UPPER:
					interval_prescaler <= i_pwdata[15:0];
				cfq_pkg::ADDR_CHAN_CTRL: chan_ctrl <= i_pwdata[1:0];
				cfq_pkg::ADDR_MSG_ID: stage_id <= i_pwdata[28:0];
				cfq_pkg::ADDR_MSG_DATA: stage_data <= i_pwdata;
				cfq_pkg::ADDR_MSG_PUSH:
					stage_remote <= i_pwdata[cfq_pkg::PUSH_REMOTE_BIT];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// FIFO storage and pointers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= '{remote: i_pwdata[cfq_pkg::PUSH_REMOTE_BIT],
				id: stage_id, data: stage_data};
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else if (!fifo_enable) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// ----------------------------------------
	// Interval tick source
	// ----------------------------------------
	logic base_tick;
	logic ten_tick;
	logic src_tick;
	assign base_tick = (pre_cnt >= interval_prescaler - 16'h0001);
	assign ten_tick = base_tick & (ten_cnt == 4'(cfq_pkg::TENFOLD - 1));
	always_comb begin
		if (interval_source_select) begin
			src_tick = chan_ctrl[cfq_pkg::CH_FD_BIT] ? i_data_bit_tick
				: i_nominal_bit_tick;
		end else if (interval_tenfold_select) begin
			src_tick = ten_tick;
		end else begin
			src_tick = base_tick;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pre_cnt <= '0;
			ten_cnt <= '0;
		end else if (state != cfq_pkg::CFQ_GAP) begin
			pre_cnt <= '0;
			ten_cnt <= '0;
		end else if (base_tick) begin
			pre_cnt <= '0;
			ten_cnt <= ten_tick ? 4'h0 : ten_cnt + 4'h1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
		end
	end

	// ----------------------------------------
	// Transmit sequencer
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= cfq_pkg::CFQ_IDLE;
			interval_count <= '0;
			first_sent <= 1'b0;
		end else if (!active) begin
			state <= cfq_pkg::CFQ_IDLE;
			interval_count <= '0;
			first_sent <= 1'b0;
		end else begin
			unique case (state)
				cfq_pkg::CFQ_IDLE: begin
					if (!fifo_empty_flag) begin
						state <= cfq_pkg::CFQ_REQUEST;
					end
				end
				cfq_pkg::CFQ_REQUEST: begin
					state <= cfq_pkg::CFQ_WAIT_DONE;
				end
				cfq_pkg::CFQ_WAIT_DONE: begin
					if (i_tx_done) begin
						first_sent <= 1'b1;
					end
					if (i_eof_bit7 && (first_sent || i_tx_done)) begin
						interval_count <= interval_field;
						state <= (interval_field == 8'h00)
							? cfq_pkg::CFQ_IDLE : cfq_pkg::CFQ_GAP;
					end
				end
				cfq_pkg::CFQ_GAP: begin
					if (src_tick) begin
						if (interval_count <= 8'h01) begin
							interval_count <= '0;
							state <= cfq_pkg::CFQ_IDLE;
						end else begin
							interval_count <= interval_count - 8'h01;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Hold back the next head until end of frame
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			await_eof <= 1'b0;
		end else if (!active || i_eof_bit7) begin
			await_eof <= 1'b0;
		end else if (done_ok) begin
			await_eof <= 1'b1;
		end
	end

	// ----------------------------------------
	// Transmit request outputs
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_tx_req <= '0;
			o_tx_abort <= 1'b0;
		end else begin
			o_tx_abort <= ~active & o_tx_req.valid;
			o_tx_req.valid <= active & ~fifo_empty_flag & ~await_eof
				& (state != cfq_pkg::CFQ_GAP) & ~pop;
			o_tx_req.slot <= fifo_link_slot_select;
			o_tx_req.msg <= mem[rd_ptr];
		end
	end

	// ----------------------------------------
	// Transmit complete flag and interrupt
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			fifo_tx_irq_flag <= 1'b0;
		end else if (done_ok && (!fifo_irq_mode || last_left)) begin
			fifo_tx_irq_flag <= 1'b1;
		end else if (clr_irq) begin
			fifo_tx_irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_tx_irq <= 1'b0;
		end else begin
			o_tx_irq <= |global_tx_irq_sources;
		end
	end

	// ----------------------------------------
	// APB read and response
	// ----------------------------------------
	always_comb begin
		lower_word = '0;
		lower_word[cfq_pkg::CFG_ENABLE_BIT] = fifo_enable;
		lower_word[cfq_pkg::CFG_TX_MODE_BIT] = tx_mode;
		lower_word[cfq_pkg::CFG_IRQ_ENABLE_BIT] = fifo_tx_irq_enable;
		lower_word[cfq_pkg::CFG_IRQ_MODE_BIT] = fifo_irq_mode;
	end

	always_comb begin
		upper_word = '0;
		upper_word[cfq_pkg::UP_INTERVAL_LSB +: 8] = interval_field;
		upper_word[cfq_pkg::UP_SOURCE_BIT] = interval_source_select;
		upper_word[cfq_pkg::UP_TENFOLD_BIT] = interval_tenfold_select;
		upper_word[cfq_pkg::UP_LINK_LSB +: 2] = fifo_link_slot_select;
	end

	always_comb begin
		status_word = '0;
		status_word[cfq_pkg::ST_EMPTY_BIT] = fifo_empty_flag;
		status_word[cfq_pkg::ST_FULL_BIT] = fifo_full;
		status_word[cfq_pkg::ST_IRQ_FLAG_BIT] = fifo_tx_irq_flag;
		status_word[cfq_pkg::ST_COUNT_LSB +: AW+1] = count;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
			if (i_psel && !i_penable) begin
				unique case (i_paddr)
					cfq_pkg::ADDR_CONFIG_LOWER: o_prdata <= lower_word;
					cfq_pkg::ADDR_CONFIG_UPPER: o_prdata <= upper_word;
					cfq_pkg::ADDR_STATUS: o_prdata <= status_word;
					cfq_pkg::ADDR_GLOBAL_UPPER:
						o_prdata <= {16'h0, interval_prescaler};
					cfq_pkg::ADDR_TX_SOURCES:
						o_prdata <= {28'h0, global_tx_irq_sources};
					cfq_pkg::ADDR_MSG_ID: o_prdata <= {3'h0, stage_id};
					cfq_pkg::ADDR_MSG_DATA: o_prdata <= stage_data;
					cfq_pkg::ADDR_MSG_PUSH: o_prdata <= {31'h0, stage_remote};
					cfq_pkg::ADDR_CHAN_CTRL: o_prdata <= {30'h0, chan_ctrl};
					default: o_pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

/* hdl/cfq_pkg.sv */
// Package for the common FIFO transmit block: map, fields, constants
package cfq_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONFIG_LOWER = 8'h00;
	localparam logic [7:0] ADDR_CONFIG_UPPER = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_GLOBAL_UPPER = 8'h0C;
	localparam logic [7:0] ADDR_TX_SOURCES = 8'h10;
	localparam logic [7:0] ADDR_MSG_ID = 8'h14;
	localparam logic [7:0] ADDR_MSG_DATA = 8'h18;
	localparam logic [7:0] ADDR_MSG_PUSH = 8'h1C;
	localparam logic [7:0] ADDR_CHAN_CTRL = 8'h20;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_TX_MODE_BIT = 1;
	localparam int CFG_IRQ_ENABLE_BIT = 2;
	localparam int CFG_IRQ_MODE_BIT = 3;
	localparam int UP_INTERVAL_LSB = 0;
	localparam int UP_SOURCE_BIT = 8;
	localparam int UP_TENFOLD_BIT = 9;
	localparam int UP_LINK_LSB = 10;
	localparam int ST_EMPTY_BIT = 0;
	localparam int ST_FULL_BIT = 1;
	localparam int ST_IRQ_FLAG_BIT = 2;
	localparam int ST_COUNT_LSB = 8;
	localparam int PUSH_REMOTE_BIT = 0;
	localparam int CH_RESET_BIT = 0;
	localparam int CH_FD_BIT = 1;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [31:0] RST_CONFIG_LOWER = 32'h0000_0000;
	localparam logic [31:0] RST_CONFIG_UPPER = 32'h0000_0000;
	localparam logic [15:0] RST_PRESCALER = 16'h0001;
	localparam logic [1:0] RST_CHAN_CTRL = 2'h1;
	localparam int FIFO_DEPTH = 16;
	localparam int TENFOLD = 10;
	localparam int CLK_MHZ = 50;
	localparam int START_LATENCY_CLKS = 120;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic remote;
		logic [28:0] id;
		logic [31:0] data;
	} cfq_msg_s;

	typedef struct packed {
		logic valid;
		logic [1:0] slot;
		cfq_msg_s msg;
	} cfq_tx_req_s;

	typedef enum logic [1:0] {
		CFQ_IDLE,
		CFQ_REQUEST,
		CFQ_WAIT_DONE,
		CFQ_GAP
	} cfq_state_e;

endpackage

/* tb/cfq_fifo_tx_monitor.sv */
// Checker for the common FIFO transmit block
module cfq_fifo_tx_monitor (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_tx_done,
	input wire logic i_buf_tx_irq,
	input wire cfq_pkg::cfq_tx_req_s o_tx_req,
	input wire logic o_tx_abort,
	input wire logic o_tx_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	chk_ready_setup: assert property (s_setup |=> s_access ##0 o_pready)
		else $error("no ready after setup");
	chk_err_unmapped: assert property (o_pready && i_paddr > 8'h20 |-> o_pslverr)
		else $error("unmapped access without error");
	chk_err_mapped: assert property
		(o_pready && i_paddr <= 8'h20 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
		else $error("mapped access with error");
	chk_head_stable: assert property
		(o_tx_req.valid && !i_tx_done |=> !o_tx_req.valid || $stable(o_tx_req.msg))
		else $error("offered head changed");
	chk_slot_stable: assert property
		(o_tx_req.valid && !i_tx_done |=> !o_tx_req.valid || $stable(o_tx_req.slot))
		else $error("linked slot changed");
	chk_done_pops: assert property
		(o_tx_req.valid && i_tx_done |-> ##[1:2] !o_tx_req.valid)
		else $error("head not popped");
	chk_abort_drops: assert property (o_tx_abort |=> !o_tx_req.valid)
		else $error("request kept after abort");
	chk_abort_cause: assert property
		(o_tx_abort |-> $past(o_tx_req.valid) || $past(o_tx_req.valid, 2))
		else $error("abort without request");
	chk_irq_merge: assert property (i_buf_tx_irq |-> ##[1:2] o_tx_irq)
		else $error("merged irq missing");
endmodule
bind cfq_fifo_tx cfq_fifo_tx_monitor u_mon (.i_clk(i_clk), .i_reset(i_reset),
	.i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_tx_done(i_tx_done),
	.i_buf_tx_irq(i_buf_tx_irq), .o_tx_req(o_tx_req),
	.o_tx_abort(o_tx_abort), .o_tx_irq(o_tx_irq));

/* tb/cfq_can_partner.sv */
// Bus side model: bit clocks and frame completion
module cfq_can_partner (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_req,
	input wire logic [7:0] i_delay,
	output logic o_nominal_tick,
	output logic o_data_tick,
	output logic o_tx_done,
	output logic o_eof_bit7
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	logic [2:0] bcnt;
	logic sent;
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			bcnt <= 3'h0;
			cnt <= 8'h00;
			sent <= 1'b0;
			o_tx_done <= 1'b0;
			o_eof_bit7 <= 1'b0;
		end else begin
			bcnt <= (bcnt == 3'h5) ? 3'h0 : bcnt + 3'h1;
			o_eof_bit7 <= o_tx_done;
			o_tx_done <= 1'b0;
			if (!i_req) begin
				cnt <= 8'h00;
				sent <= 1'b0;
			end else if (!sent && cnt == i_delay) begin
				o_tx_done <= 1'b1;
				sent <= 1'b1;
			end else if (!sent) begin
				cnt <= cnt + 8'h01;
			end
		end
	end
	assign o_nominal_tick = (bcnt == 3'h0);
	assign o_data_tick = bcnt[0];
endmodule

/* tb/cfq_fifo_tx_test.sv */
// Testbench for the common FIFO transmit block
module cfq_fifo_tx_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr, err;
	logic nt, dt, done, eof, abort, irq, seen;
	logic [2:0] src;
	logic [7:0] paddr, delay;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] ut [4] = '{32'h804, 32'hA03, 32'h903, 32'h903};
	logic [31:0] pt [4] = '{32'h3, 32'h1, 32'h1, 32'h1};
	logic [31:0] ct [4] = '{32'h0, 32'h0, 32'h0, 32'h2};
	int et [4] = '{12, 30, 18, 6};
	int pe [4] = '{3, 10, 6, 2};
	int fails, compares, cyc, gap;
	cfq_pkg::cfq_tx_req_s req;
	cfq_fifo_tx u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_nominal_bit_tick(nt), .i_data_bit_tick(dt),
		.i_eof_bit7(eof), .i_tx_done(done), .i_buf_tx_irq(src[0]),
		.i_buf_abort_irq(src[1]), .i_history_irq(src[2]), .o_tx_req(req),
		.o_tx_abort(abort), .o_tx_irq(irq));
	cfq_can_partner u_can (.i_clk(i_clk), .i_reset(i_reset),
		.i_req(req.valid), .i_delay(delay), .o_nominal_tick(nt),
		.o_data_tick(dt), .o_tx_done(done), .o_eof_bit7(eof));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (abort)
			seen <= 1'b1;
		if (cyc == 30000) begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic push(input logic [31:0] id);
		apb(1'b1, cfq_pkg::ADDR_MSG_ID, id);
		apb(1'b1, cfq_pkg::ADDR_MSG_DATA, ~id);
		apb(1'b1, cfq_pkg::ADDR_MSG_PUSH, {31'h0, id[0]});
	endtask
	task automatic wait_done();
		do @(negedge i_clk); while (done !== 1'b1);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, src, seen} = '0;
		i_reset = 1'b1;
		delay = 8'h04;
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		rdc(cfq_pkg::ADDR_CONFIG_LOWER, 32'h0, "cfg_lower");
		rdc(cfq_pkg::ADDR_STATUS, 32'h1, "status");
		rdc(cfq_pkg::ADDR_GLOBAL_UPPER, 32'h1, "prescaler");
		rdc(cfq_pkg::ADDR_CHAN_CTRL, 32'h1, "chan_ctrl");
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		$display("test reset done");
		apb(1'b1, cfq_pkg::ADDR_CONFIG_UPPER, 32'h800);
		apb(1'b1, cfq_pkg::ADDR_CONFIG_LOWER, 32'hF);
		for (int i = 0; i < 17; i++)
			push(i);
		rdc(cfq_pkg::ADDR_STATUS, 32'h1002, "full_status");
		apb(1'b1, cfq_pkg::ADDR_CHAN_CTRL, 32'h0);
		for (int i = 0; i < 16; i++) begin
			wait_done();
			chk("order_id", i, {3'h0, req.msg.id});
			chk("remote", i % 2, {31'h0, req.msg.remote});
			chk("slot", 32'h2, {30'h0, req.slot});
		end
		rdc(cfq_pkg::ADDR_STATUS, 32'h5, "empty_irq");
		chk("irq_line", 32'h1, {31'h0, irq});
		apb(1'b1, cfq_pkg::ADDR_STATUS, 32'h4);
		repeat (3) @(negedge i_clk);
		chk("irq_clear", 32'h0, {31'h0, irq});
		$display("test fill done");
		apb(1'b1, cfq_pkg::ADDR_CONFIG_LOWER, 32'h3);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, cfq_pkg::ADDR_GLOBAL_UPPER, pt[m]);
			apb(1'b1, cfq_pkg::ADDR_CHAN_CTRL, 32'h1);
			apb(1'b1, cfq_pkg::ADDR_CONFIG_UPPER, ut[m]);
			push(32'h40);
			push(32'h41);
			@(negedge i_clk);
			chk("held_in_reset", 32'h0, {31'h0, req.valid});
			apb(1'b1, cfq_pkg::ADDR_CHAN_CTRL, ct[m]);
			repeat (2) @(negedge i_clk);
			chk("prompt_req", 32'h1, {31'h0, req.valid});
			wait_done();
			gap = 0;
			do begin
				@(negedge i_clk);
				gap++;
			end while (req.valid);
			while (!req.valid) begin
				@(negedge i_clk);
				gap++;
			end
			chk("gap_in_range", 32'h1,
				{31'h0, gap >= et[m] - pe[m] && gap <= et[m] + pe[m] + 6});
			wait_done();
		end
		$display("test interval done");
		apb(1'b1, cfq_pkg::ADDR_CONFIG_UPPER, 32'h800);
		apb(1'b1, cfq_pkg::ADDR_CONFIG_LOWER, 32'h7);
		delay <= 8'h30;
		push(32'h50);
		push(32'h51);
		wait_done();
		do @(negedge i_clk); while (!req.valid);
		apb(1'b1, cfq_pkg::ADDR_CONFIG_LOWER, 32'h6);
		repeat (3) @(negedge i_clk);
		chk("abort_seen", 32'h1, {31'h0, seen});
		chk("req_dropped", 32'h0, {31'h0, req.valid});
		rdc(cfq_pkg::ADDR_STATUS, 32'h5, "flag_kept");
		apb(1'b1, cfq_pkg::ADDR_STATUS, 32'h4);
		rdc(cfq_pkg::ADDR_STATUS, 32'h1, "no_abort_irq");
		$display("test abort done");
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			src <= 3'h1 << k;
			repeat (3) @(negedge i_clk);
			chk("tx_irq", 32'h1, {31'h0, irq});
			rdc(cfq_pkg::ADDR_TX_SOURCES, (k == 2) ? 32'h8 : 32'h1 << k, "src");
		end
		$display("test sources done");
		summarize();
	end
endmodule
